//--- access_timer.sv
/*
  Down counter that times one phase of a memory access.
  Assumes the caller loads a length of at least one and watches done.
*/
`timescale 1ns/100ps
module access_timer (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       load,
  input  wire logic [8:0] len,
  // Status
  output logic            done
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;

  // Done marks the last cycle of the phase that was loaded
  assign done  = (cnt_q == static_mem_ctrl_pkg::LEN_ONE);
  assign cnt_d = load ? len :
                 (cnt_q != 9'h000) ? cnt_q - static_mem_ctrl_pkg::LEN_ONE : cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 9'h000;
    else          cnt_q <= cnt_d;
  end

endmodule : access_timer

//--- page_memory_model.sv
/* Behavioural page-mode memory for the read block bench.
   Assumes active-low select and strobe and a byte address, aligned or not. */
`timescale 1ns/100ps
module page_memory_model (
  // Clock
  input wire logic        aclk,
  // Memory pins
  input wire logic [7:0]  chip_sel_n,
  input wire logic        read_strobe_n,
  input wire logic [25:0] mem_addr,
  output logic [31:0]     mem_rdata
);
  // ------------------------
  // Read data
  // ------------------------
  logic [31:0] last_q = 32'h0;
  wire logic        sel  = !read_strobe_n && (chip_sel_n != 8'hFF);
  wire logic [31:0] word = {mem_addr[15:0], ~mem_addr[15:0]};
  always @(posedge aclk) begin
    if (sel) last_q <= word;
  end
  // No wait line; an idle bus shows ~last word so stale data fails
  assign mem_rdata = sel ? word : ~last_q;
endmodule : page_memory_model

//--- static_mem_ctrl_pkg.sv
/*
  Constants, field layouts, types and helpers shared by the page-mode read
  block of the static memory controller and its cycle timer.
  Assumes a single clock domain and a register map reached over AXI4-Lite.
*/
// Operation
// R1: Page bursts only when page-mode enable set
// R2: Pages are size-aligned consecutive byte blocks
// R3: Upper address bits form page address
// R4: Ignore low address bits for wide memories
// R5: Strobe and select stay low through page
// R6: First access cs pulse, later read pulse
// R7: Page mode ignores setups, mode, cycle
// R8: No timing coherency check applied
// R9: Byte access type stays active in page
// R10: Software never mixes external wait, page mode
// R11: Same select and page gives short access
// R12: New page address gives long access
// R13: Chip select change breaks the page
// R14: Intervening access breaks the page
// R15: Four registers per select, 16-byte stride
// R16: Configuration completes with mode write
// R17: Setup length is 128*b5 plus b[4:0]
// R18: Pulse length is 256*b6 plus b[5:0]
// R19: Page record invalidated on reset, release
package static_mem_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Sizes and register map
  // ----------------------------------------------------------------------
  localparam int          NUM_CS       = 8;
  localparam int          ADDR_W       = 26;
  localparam int          DATA_W       = 32;
  localparam int          BUS_ADDR_W   = 8;
  localparam int          LEN_W        = 9;
  localparam int          CS_W         = 3;
  localparam int          REG_LSB      = 2;
  localparam int          CS_LSB       = 4;
  localparam logic [7:0]  MAP_TOP      = 8'h80;
  localparam logic [1:0]  REG_SETUP    = 2'h0;
  localparam logic [1:0]  REG_PULSE    = 2'h1;
  localparam logic [1:0]  REG_CYCLE    = 2'h2;
  localparam logic [1:0]  REG_MODE     = 2'h3;
  localparam logic [31:0] SETUP_RESET  = 32'h0000_0000;
  localparam logic [31:0] PULSE_RESET  = 32'h0101_0101;
  localparam logic [31:0] CYCLE_RESET  = 32'h0003_0003;
  localparam logic [31:0] MODE_RESET   = 32'h1000_1000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RD_SETUP_LSB    = 16;
  localparam int CS_RD_PULSE_LSB = 24;
  localparam int RD_PULSE_LSB    = 16;
  localparam int MODE_BAT_BIT    = 8;
  localparam int MODE_DBW_LSB    = 12;
  localparam int MODE_PAGE_MODE_ENABLE_BIT   = 24;
  localparam int MODE_PS_LSB     = 28;

  localparam logic [1:0]  DBW_16 = 2'h1;
  localparam logic [1:0]  DBW_32 = 2'h2;
  localparam logic [4:0]  PAGE_MIN_SHIFT  = 5'h02;
  localparam logic [8:0]  SETUP_HI_WEIGHT = 9'h080;
  localparam logic [8:0]  PULSE_HI_WEIGHT = 9'h100;
  localparam logic [8:0]  LEN_ONE         = 9'h001;
  localparam logic [25:0] ADDR_ONES       = 26'h3ff_ffff;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                  awvalid;
    logic [BUS_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [DATA_W-1:0]     wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [BUS_ADDR_W-1:0] araddr;
    logic                  rready;
  } axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic              valid;
    logic [CS_W-1:0]   cs;
    logic [ADDR_W-1:0] addr;
  } rd_req_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETUP   = 3'b001,
    ST_PULSE   = 3'b010,
    ST_OPEN    = 3'b011,
    ST_RELEASE = 3'b100
  } rd_state_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [8:0] setup_len(input logic [5:0] f);
    setup_len = (f[5] ? SETUP_HI_WEIGHT : 9'h000) + {4'h0, f[4:0]}; // R17
  endfunction : setup_len

  // A zero pulse is illegal; it is stretched to one cycle so the FSM moves
  function automatic logic [8:0] pulse_len(input logic [6:0] f);
    logic [8:0] n;
    n = (f[6] ? PULSE_HI_WEIGHT : 9'h000) + {3'h0, f[5:0]}; // R18
    pulse_len = (n == 9'h000) ? LEN_ONE : n;
  endfunction : pulse_len

  function automatic logic [25:0] page_base(input logic [25:0] a,
                                            input logic [1:0]  ps);
    page_base = a & (ADDR_ONES << (PAGE_MIN_SHIFT + {3'h0, ps})); // R2 R3
  endfunction : page_base

  function automatic logic [25:0] word_addr(input logic [25:0] a,
                                            input logic [1:0]  dbw);
    word_addr = a;
    if (dbw == DBW_16) word_addr[0] = 1'b0; // R4
    if (dbw == DBW_32) word_addr[1:0] = 2'h0; // R4
  endfunction : word_addr

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

endpackage : static_mem_ctrl_pkg

//--- static_mem_page_read.sv
/*
  Page-mode read engine and per-chip-select timing registers of the static
  memory controller, with an AXI4-Lite register slave.
  Assumes memory read data is stable at the end of each strobe pulse and
  that the system bus flags any other access that borrows the memory pins.
*/
`timescale 1ns/100ps
module static_mem_page_read (
  // Clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // Register bus
  input  wire static_mem_ctrl_pkg::axil_req_t   axil_req,
  output static_mem_ctrl_pkg::axil_rsp_t        axil_rsp,
  // Read requests from the system bus
  input  wire static_mem_ctrl_pkg::rd_req_t     rd_req,
  output logic                                  rd_ready,
  output logic                                  rd_done,
  output logic [31:0]                           rd_data,
  input  wire logic                             other_access,
  // Memory pins
  output logic [7:0]                            chip_sel_n,
  output logic                                  read_strobe_n,
  output logic [3:0]                            byte_sel_n,
  output logic [25:0]                           mem_addr,
  input  wire logic [31:0]                      mem_rdata
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [31:0] cfg_q   [static_mem_ctrl_pkg::NUM_CS][4];
  logic [31:0] setup_q [static_mem_ctrl_pkg::NUM_CS];
  logic [31:0] pulse_q [static_mem_ctrl_pkg::NUM_CS];

  logic        aw_have_q;
  logic [7:0]  aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire         do_write  = aw_have_q & w_have_q & ~bvalid_q;
  wire         w_mapped  = aw_addr_q < static_mem_ctrl_pkg::MAP_TOP;
  wire [2:0]   w_cs      = aw_addr_q[static_mem_ctrl_pkg::CS_LSB +: 3]; // R15
  wire [1:0]   w_reg     = aw_addr_q[static_mem_ctrl_pkg::REG_LSB +: 2]; // R15
  wire         mode_wr   = do_write & w_mapped & (w_reg == static_mem_ctrl_pkg::REG_MODE);
  wire         ar_take   = axil_req.arvalid & ~rvalid_q;
  wire         r_mapped  = axil_req.araddr < static_mem_ctrl_pkg::MAP_TOP;
  wire [2:0]   r_cs      = axil_req.araddr[static_mem_ctrl_pkg::CS_LSB +: 3];
  wire [1:0]   r_reg     = axil_req.araddr[static_mem_ctrl_pkg::REG_LSB +: 2];
  wire [31:0]  r_word    = r_mapped ? cfg_q[r_cs][r_reg] : 32'h0000_0000;

  assign axil_rsp.awready = ~aw_have_q;
  assign axil_rsp.wready  = ~w_have_q;
  assign axil_rsp.bvalid  = bvalid_q;
  assign axil_rsp.bresp   = bresp_q;
  assign axil_rsp.arready = ~rvalid_q;
  assign axil_rsp.rvalid  = rvalid_q;
  assign axil_rsp.rdata   = rdata_q;
  assign axil_rsp.rresp   = rresp_q;

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= static_mem_ctrl_pkg::RESP_OKAY;
    end else begin
      if (axil_req.awvalid & ~aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= axil_req.awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (axil_req.wvalid & ~w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= axil_req.wdata;
        w_strb_q <= axil_req.wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= w_mapped ? static_mem_ctrl_pkg::RESP_OKAY
                             : static_mem_ctrl_pkg::RESP_DECERR;
      end else if (axil_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= static_mem_ctrl_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= r_word;
      rresp_q  <= r_mapped ? static_mem_ctrl_pkg::RESP_OKAY
                           : static_mem_ctrl_pkg::RESP_DECERR;
    end else if (axil_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  // Software-visible words change at once; the timing copies the engine
  // uses only follow a mode write, so a half-written set is never used.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < static_mem_ctrl_pkg::NUM_CS; c++) begin
        cfg_q[c][static_mem_ctrl_pkg::REG_SETUP] <= static_mem_ctrl_pkg::SETUP_RESET;
        cfg_q[c][static_mem_ctrl_pkg::REG_PULSE] <= static_mem_ctrl_pkg::PULSE_RESET;
        cfg_q[c][static_mem_ctrl_pkg::REG_CYCLE] <= static_mem_ctrl_pkg::CYCLE_RESET;
        cfg_q[c][static_mem_ctrl_pkg::REG_MODE]  <= static_mem_ctrl_pkg::MODE_RESET;
        setup_q[c] <= static_mem_ctrl_pkg::SETUP_RESET;
        pulse_q[c] <= static_mem_ctrl_pkg::PULSE_RESET;
      end
    end else begin
      if (do_write & w_mapped) begin
        cfg_q[w_cs][w_reg] <= static_mem_ctrl_pkg::merge(cfg_q[w_cs][w_reg],
                                                         w_data_q, w_strb_q);
      end
      if (mode_wr) begin
        for (int c = 0; c < static_mem_ctrl_pkg::NUM_CS; c++) begin
          setup_q[c] <= cfg_q[c][static_mem_ctrl_pkg::REG_SETUP]; // R16
          pulse_q[c] <= cfg_q[c][static_mem_ctrl_pkg::REG_PULSE]; // R16
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read engine
  // ----------------------------------------------------------------------
  static_mem_ctrl_pkg::rd_state_t st_q;
  static_mem_ctrl_pkg::rd_state_t st_d;

  logic        page_vld_q;
  logic [2:0]  page_cs_q;
  logic [25:0] page_base_q;
  logic [2:0]  acc_cs_q;
  logic        done_q;
  logic [31:0] data_q;
  logic [7:0]  cs_n_q;
  logic        rd_n_q;
  logic [3:0]  be_n_q;
  logic [25:0] addr_q;
  logic        t_done;
  logic        t_load;
  logic [8:0]  t_len;

  wire [2:0]  cur_cs   = (st_q == static_mem_ctrl_pkg::ST_IDLE) ? rd_req.cs : acc_cs_q;
  wire [31:0] cur_mode = cfg_q[cur_cs][static_mem_ctrl_pkg::REG_MODE];
  wire [31:0] cur_pul  = pulse_q[cur_cs];
  wire [31:0] cur_set  = setup_q[cur_cs];
  wire        cur_page_mode_enable = cur_mode[static_mem_ctrl_pkg::MODE_PAGE_MODE_ENABLE_BIT]; // R1
  wire [1:0]  cur_ps   = cur_mode[static_mem_ctrl_pkg::MODE_PS_LSB +: 2];
  wire [1:0]  cur_dbw  = cur_mode[static_mem_ctrl_pkg::MODE_DBW_LSB +: 2];
  wire        cur_bat  = cur_mode[static_mem_ctrl_pkg::MODE_BAT_BIT];
  wire [25:0] req_base = static_mem_ctrl_pkg::page_base(rd_req.addr, cur_ps);
  wire        req_hit  = page_vld_q & cur_page_mode_enable & (rd_req.cs == page_cs_q)  // R13
                         & (req_base == page_base_q); // R11 R12
  // Page mode: first access uses the select pulse, no setup is applied
  wire [8:0]  first_len = static_mem_ctrl_pkg::pulse_len(
                            cur_pul[static_mem_ctrl_pkg::CS_RD_PULSE_LSB +: 7]); // R6 R7 R8
  wire [8:0]  next_len  = static_mem_ctrl_pkg::pulse_len(
                            cur_pul[static_mem_ctrl_pkg::RD_PULSE_LSB +: 7]); // R6 R8
  wire [8:0]  set_len   = static_mem_ctrl_pkg::setup_len(
                            cur_set[static_mem_ctrl_pkg::RD_SETUP_LSB +: 6]);
  wire        take_idle = (st_q == static_mem_ctrl_pkg::ST_IDLE) & rd_req.valid;
  wire        take_hit  = (st_q == static_mem_ctrl_pkg::ST_OPEN) & rd_req.valid
                          & req_hit & ~other_access; // R11

  assign rd_ready = take_idle | take_hit;

  always_comb begin
    st_d   = st_q;
    t_load = 1'b0;
    t_len  = next_len;
    unique case (st_q)
      static_mem_ctrl_pkg::ST_IDLE: begin
        if (rd_req.valid) begin
          t_load = 1'b1;
          if (cur_page_mode_enable) begin
            st_d  = static_mem_ctrl_pkg::ST_PULSE;
            t_len = first_len; // R12
          end else if (set_len != 9'h000) begin
            st_d  = static_mem_ctrl_pkg::ST_SETUP;
            t_len = set_len;
          end else begin
            st_d = static_mem_ctrl_pkg::ST_PULSE;
          end
        end
      end
      static_mem_ctrl_pkg::ST_SETUP: begin
        if (t_done) begin
          st_d   = static_mem_ctrl_pkg::ST_PULSE;
          t_load = 1'b1;
        end
      end
      static_mem_ctrl_pkg::ST_PULSE: begin
        if (t_done) begin
          st_d = page_vld_q ? static_mem_ctrl_pkg::ST_OPEN
                            : static_mem_ctrl_pkg::ST_RELEASE;
        end
      end
      static_mem_ctrl_pkg::ST_OPEN: begin
        if (other_access) begin
          st_d = static_mem_ctrl_pkg::ST_RELEASE; // R14
        end else if (take_hit) begin
          st_d   = static_mem_ctrl_pkg::ST_PULSE;
          t_load = 1'b1; // R6
        end else if (rd_req.valid) begin
          st_d = static_mem_ctrl_pkg::ST_RELEASE; // R12 R13
        end
      end
      static_mem_ctrl_pkg::ST_RELEASE: begin
        st_d = static_mem_ctrl_pkg::ST_IDLE;
      end
      default: begin
        st_d = static_mem_ctrl_pkg::ST_RELEASE;
      end
    endcase
  end

  access_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (t_load),
    .len     (t_len),
    .done    (t_done)
  );

  // Pins follow the next state so they change on the same edge as the FSM
  wire sel_d  = (st_d == static_mem_ctrl_pkg::ST_SETUP) |
                (st_d == static_mem_ctrl_pkg::ST_PULSE) |
                (st_d == static_mem_ctrl_pkg::ST_OPEN);
  // In page mode the strobe follows the select exactly, across the page
  wire strb_d = (st_d == static_mem_ctrl_pkg::ST_PULSE) |
                (st_d == static_mem_ctrl_pkg::ST_OPEN); // R5
  wire [2:0] sel_cs = rd_ready ? rd_req.cs : acc_cs_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= static_mem_ctrl_pkg::ST_IDLE;
      page_vld_q  <= 1'b0; // R19
      page_cs_q   <= 3'h0;
      page_base_q <= 26'h000_0000;
      acc_cs_q    <= 3'h0;
      done_q      <= 1'b0;
      data_q      <= 32'h0000_0000;
      cs_n_q      <= 8'hff;
      rd_n_q      <= 1'b1;
      be_n_q      <= 4'hf;
      addr_q      <= 26'h000_0000;
    end else begin
      st_q   <= st_d;
      done_q <= (st_q == static_mem_ctrl_pkg::ST_PULSE) & t_done;
      if ((st_q == static_mem_ctrl_pkg::ST_PULSE) & t_done) begin
        data_q <= mem_rdata;
      end
      if (take_idle) begin
        acc_cs_q    <= rd_req.cs;
        page_vld_q  <= cur_page_mode_enable; // R1
        page_cs_q   <= rd_req.cs;
        page_base_q <= req_base;
      end else if (st_d == static_mem_ctrl_pkg::ST_RELEASE) begin
        page_vld_q <= 1'b0; // R19
      end
      if (rd_ready) begin
        addr_q <= static_mem_ctrl_pkg::word_addr(rd_req.addr, cur_dbw); // R4
      end
      cs_n_q <= ~({7'h00, sel_d} << sel_cs);
      rd_n_q <= ~strb_d;
      // Byte selects stay with the strobe in byte-select mode
      be_n_q <= (strb_d & ~cur_bat) ? 4'h0 : 4'hf; // R9
    end
  end

  assign rd_done       = done_q;
  assign rd_data       = data_q;
  assign chip_sel_n    = cs_n_q;
  assign read_strobe_n = rd_n_q;
  assign byte_sel_n    = be_n_q;
  assign mem_addr      = addr_q;

endmodule : static_mem_page_read

//--- static_mem_page_read_bench.sv
/* Self-checking bench for the page-mode read block.
   Assumes the package, block, checker and memory model are compiled first. */
`timescale 1ns/100ps
module static_mem_page_read_bench;
  // ------------------------
  // Signals
  // ------------------------
  logic                           aclk = 1'b0, aresetn = 1'b0, other_access = 1'b0;
  static_mem_ctrl_pkg::axil_req_t axil_req = '0;
  static_mem_ctrl_pkg::rd_req_t   rd_req = '0;
  static_mem_ctrl_pkg::axil_rsp_t axil_rsp;
  logic                           rd_ready, rd_done, read_strobe_n;
  logic [31:0]                    rd_data, mem_rdata;
  logic [7:0]                     chip_sel_n;
  logic [3:0]                     byte_sel_n;
  logic [25:0]                    mem_addr;
  int                             miscompares = 0, total_checks = 0;
  localparam logic [25:0] M8  = 26'h3ff_ffff;
  localparam logic [25:0] M16 = 26'h3ff_fffe;
  logic [31:0] rst_v [4] = '{32'h0, 32'h0101_0101, 32'h0003_0003, 32'h1000_1000};
  // Second entry has a first access shorter than the in-page one
  logic [31:0] pul_v [4] = '{32'h0302_0000, 32'h0104_0000, 32'h4101_0000, 32'h0102_0000};
  int          opn_v [4] = '{4, 2, 258, 2};
  int          hit_v [4] = '{3, 5, 2, 3};

  always #25 aclk = ~aclk;

  static_mem_page_read u_dut (
    .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .rd_req(rd_req), .rd_ready(rd_ready), .rd_done(rd_done), .rd_data(rd_data),
    .other_access(other_access), .chip_sel_n(chip_sel_n),
    .read_strobe_n(read_strobe_n), .byte_sel_n(byte_sel_n), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  page_memory_model u_mem (
    .aclk(aclk), .chip_sel_n(chip_sel_n), .read_strobe_n(read_strobe_n),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  // ------------------------
  // Tasks
  // ------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bounds every wait; a hang ends the run as a mismatch
  task automatic stall(inout int k);
    k++;
    if (k > 1000) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : stall

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic [1:0] rs);
    int k = 0;
    logic [2:0] s;
    logic dn;
    @(posedge aclk);
    if (wr) axil_req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: wd,
                          wstrb: 4'hF, bready: 1'b1, default: '0};
    else axil_req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(negedge aclk);
      stall(k);
      s = {axil_rsp.awready, axil_rsp.wready, axil_rsp.arready};
      dn = wr ? axil_rsp.bvalid : axil_rsp.rvalid;
      rd = axil_rsp.rdata;
      rs = wr ? axil_rsp.bresp : axil_rsp.rresp;
      @(posedge aclk);
      if (s[2]) axil_req.awvalid <= 1'b0;
      if (s[1]) axil_req.wvalid <= 1'b0;
      if (s[0]) axil_req.arvalid <= 1'b0;
    end while (dn !== 1'b1);
    axil_req.bready <= 1'b0;
    axil_req.rready <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rv;
    logic [1:0] rs;
    bus(1'b1, a, d, rv, rs);
    chk({30'h0, rs}, 32'h0);
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] rv;
    logic [1:0] rs;
    bus(1'b0, a, 32'h0, rv, rs);
    chk(rv, e);
    chk({30'h0, rs}, {30'h0, er});
  endtask : rchk

  // Reads one word and checks its length from take to done
  task automatic mrd(input logic [2:0] cs, input logic [25:0] a, input int len,
                     input logic pg, input logic [25:0] m);
    int k = 0;
    int n = 0;
    logic [25:0] wa;
    wa = a & m;
    @(posedge aclk);
    rd_req <= '{valid: 1'b1, cs: cs, addr: a};
    do begin
      @(negedge aclk);
      stall(k);
    end while (rd_ready !== 1'b1);
    @(posedge aclk);
    rd_req.valid <= 1'b0;
    do begin
      @(negedge aclk);
      stall(k);
      n++;
      if (read_strobe_n === 1'b0) chk({28'h0, byte_sel_n}, 32'h0);
    end while (rd_done !== 1'b1);
    chk(n, len);
    chk(rd_data, {wa[15:0], ~wa[15:0]});
    if (pg) chk({23'h0, read_strobe_n, chip_sel_n}, {24'h0, ~(8'h01 << cs)});
  endtask : mrd

  // ------------------------
  // Tests
  // ------------------------
  initial begin
    logic [25:0] b;
    logic [25:0] sz;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int c = 0; c < 8; c += 7) begin
      for (int r = 0; r < 4; r++) rchk({c[3:0], r[1:0], 2'b00}, rst_v[r], 2'h0);
    end
    wreg(8'h58, 32'h0123_0045);
    rchk(8'h58, 32'h0123_0045, 2'h0);
    rchk(8'h80, 32'h0, 2'h3);
    $display("test registers done");
    mrd(3'h0, 26'h105, 2, 1'b0, M16);
    $display("test plain read done");
    wreg(8'h20, 32'h0021_0000);
    wreg(8'h30, 32'h0021_0000);
    wreg(8'h24, 32'h0502_0000);
    wreg(8'h2C, 32'h1100_0000);
    mrd(3'h2, 26'h1001, 6, 1'b1, M8);
    mrd(3'h2, 26'h1003, 3, 1'b1, M8);
    mrd(3'h2, 26'h1000, 3, 1'b1, M8);
    mrd(3'h2, 26'h1008, 6, 1'b1, M8);
    mrd(3'h3, 26'h1008, 131, 1'b0, M16);
    mrd(3'h2, 26'h1009, 6, 1'b1, M8);
    @(posedge aclk);
    other_access <= 1'b1;
    @(posedge aclk);
    other_access <= 1'b0;
    mrd(3'h2, 26'h100A, 6, 1'b1, M8);
    $display("test page hits done");
    for (int k = 0; k < 4; k++) begin
      b = 26'h2000 + 26'(k * 64);
      sz = 26'(4 << k);
      wreg(8'h24, pul_v[k]);
      wreg(8'h2C, {2'b00, k[1:0], 28'h100_0000});
      mrd(3'h2, b, opn_v[k], 1'b1, M8);
      mrd(3'h2, b + sz - 26'h1, hit_v[k], 1'b1, M8);
      mrd(3'h2, b + sz, opn_v[k], 1'b1, M8);
    end
    $display("test page sizes done");
    tally_and_finish();
  end
endmodule : static_mem_page_read_bench

//--- static_mem_page_read_props.sv
/* Port checker for the page-mode read block.
   Assumes it is bound to the block and sees only its ports. */
`timescale 1ns/100ps
module static_mem_page_read_props (
  // Clock and reset
  input wire logic                           aclk,
  input wire logic                           aresetn,
  // Register bus
  input wire static_mem_ctrl_pkg::axil_req_t axil_req,
  input wire static_mem_ctrl_pkg::axil_rsp_t axil_rsp,
  // Read port
  input wire static_mem_ctrl_pkg::rd_req_t   rd_req,
  input wire logic                           rd_ready,
  input wire logic                           rd_done,
  input wire logic [31:0]                    rd_data,
  input wire logic                           other_access,
  // Memory pins
  input wire logic [7:0]                     chip_sel_n,
  input wire logic                           read_strobe_n,
  input wire logic [31:0]                    mem_rdata
);
  // ------------------------
  // Properties
  // ------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_STROBE_SEL: assert property (!read_strobe_n |-> chip_sel_n != 8'hFF)
    else $error("strobe without select");
  AST_SEL_TAKE: assert property ((rd_req.valid && rd_ready && &chip_sel_n)
    |=> chip_sel_n == ~(8'h01 << $past(rd_req.cs)))
    else $error("select missing after take");
  AST_OTHER_BREAK: assert property ((other_access && chip_sel_n != 8'hFF) |-> !rd_ready)
    else $error("take during other access");
  AST_TAKE_BOUND: assert property (rd_req.valid |-> ##[0:400] rd_ready)
    else $error("request not taken");
  AST_DONE_DATA: assert property (rd_done |-> rd_data == $past(mem_rdata))
    else $error("stale read data");
  AST_DONE_PULSE: assert property (rd_done |=> !rd_done)
    else $error("done held");
  AST_B_ANSWER: assert property ((axil_req.awvalid && axil_rsp.awready &&
    axil_req.wvalid && axil_rsp.wready && !axil_rsp.bvalid) |-> ##[1:2] axil_rsp.bvalid)
    else $error("write response missing");
  AST_AR_ANSWER: assert property ((axil_req.arvalid && axil_rsp.arready)
    |=> axil_rsp.rvalid)
    else $error("read response missing");
  AST_UNMAPPED: assert property ((axil_req.arvalid && axil_rsp.arready &&
    axil_req.araddr >= static_mem_ctrl_pkg::MAP_TOP)
    |=> (axil_rsp.rresp == static_mem_ctrl_pkg::RESP_DECERR && axil_rsp.rdata == 32'h0))
    else $error("unmapped read not refused");

  COV_PAGE_HELD: cover property (rd_done && !read_strobe_n);
  COV_OTHER: cover property (other_access && chip_sel_n != 8'hFF);
  COV_DECERR: cover property (axil_rsp.rvalid && axil_rsp.rresp == 2'h3);
endmodule : static_mem_page_read_props

bind static_mem_page_read static_mem_page_read_props u_props (
  .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .rd_req(rd_req), .rd_ready(rd_ready), .rd_done(rd_done), .rd_data(rd_data),
  .other_access(other_access), .chip_sel_n(chip_sel_n),
  .read_strobe_n(read_strobe_n), .mem_rdata(mem_rdata));
